// ### logic/rxd_defines.svh
// Overview of operation
// - Run bit starts independent receive process
// - Running process polls list, writes status
// - Fetch next descriptor on listed events
// - Filter frames by mode bits; purge failures
// - Purge runts unless pass-bad-frames set
// - Request bus after 64 bytes or whole frame stored
// - Mark first descriptor once bus gained
// - Release descriptor on fill or frame end
// - Single-descriptor frame has first and last
// - Close last descriptor, then raise receive flag
// - Host-owned descriptor: flag, suspend, keep position
// - Suspended frame arrival re-reads current descriptor
// - Still host-owned: drop frame, count missed
// - Start resumes position, or head if new
// - Stop after current frame; flag stopped
// - Bus error halts until software reset
// - Reset cuts reception, process stopped
// - Poll demand resumes suspended process
// - Stop while suspended: stopped, flag set
// - Status bits clear by writing one
`ifndef RXD_DEFINES_SVH
`define RXD_DEFINES_SVH
`define RXD_A_BUSMODE 8'h00
`define RXD_A_POLL 8'h04
`define RXD_A_RXBASE 8'h08
`define RXD_A_STATUS 8'h0C
`define RXD_A_OPMODE 8'h10
`define RXD_A_IMASK 8'h14
`define RXD_A_MISSED 8'h18
`define RXD_SWR 0
`define RXD_HP 0
`define RXD_RUN 1
`define RXD_HO 2
`define RXD_PB 3
`define RXD_INV 6
`define RXD_RI 6
`define RXD_RBU 7
`define RXD_RPS 8
`define RXD_FBE 13
`define RXD_PS_HI 19
`define RXD_PS_LO 17
`define RXD_OWN 31
`define RXD_FS 9
`define RXD_LS 8
`define RXD_LEN_HI 29
`define RXD_LEN_LO 16
`define RXD_MIN_FRAME 14'h0040
`define RXD_RST_WAIT_CYC 6'h32
`define RXD_WORD 11'h004
`define RXD_RSP_OK 2'h0
`define RXD_RSP_DEC 2'h3
`define RXD_PS_STOP 3'h0
`define RXD_PS_FETCH 3'h1
`define RXD_PS_WAIT 3'h3
`define RXD_PS_SUSP 3'h4
`define RXD_PS_CLOSE 3'h5
`define RXD_PS_XFER 3'h7
`endif

// ### logic/rxd_dma.sv
`include "rxd_defines.svh"

module rxd_dma (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite register slave
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Host memory master
    output rxd_pkg::rxd_mem_req_t mem_req,
    input wire rxd_pkg::rxd_mem_rsp_t mem_rsp,
    // Receive FIFO
    input wire rxd_pkg::rxd_frm_t frm,
    input wire rxd_pkg::rxd_word_t rx_word,
    output logic rx_pop,
    output logic rx_drop
);
    import rxd_pkg::*;

    rxd_state_t s_r;
    rxd_state_t s_nxt;
    logic keep;
    logic big;
    logic runt;
    logic run;
    logic wr_go;
    logic poll;
    logic swr;
    logic bus_ok;
    logic [31:0] rd_val;
    logic [1:0] rd_resp;
    logic [2:0] ps;
    logic [31:0] dw;

    function automatic logic flt_pass(logic [31:0] om, rxd_frm_t f);
        if (om[`RXD_INV]) return !f.perf_hit;
        if (om[`RXD_HO]) return f.hash_hit;
        if (om[`RXD_HP]) return f.hash_hit || f.perf_hit;
        return f.perf_hit;
    endfunction

    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] b);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        return (o & ~m) | (d & m);
    endfunction

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    // bus held off after reset
    assign bus_ok = s_r.rstcnt == `RXD_RST_WAIT_CYC;
    assign awready = bus_ok && !s_r.aw_h;
    assign wready = bus_ok && !s_r.w_h;
    assign arready = bus_ok && !s_r.rvalid;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
    assign mem_req = s_r.mreq;
    assign run = s_r.opmode[`RXD_RUN];

    always_comb begin
        unique case (s_r.st)
            S_STOP: ps = `RXD_PS_STOP;
            S_WAIT, S_DROP: ps = `RXD_PS_WAIT;
            S_SUSP: ps = `RXD_PS_SUSP;
            S_CLOSE: ps = `RXD_PS_CLOSE;
            S_XFER: ps = `RXD_PS_XFER;
            // Fatal halt still reads as running
            default: ps = `RXD_PS_FETCH;
        endcase
        rd_resp = `RXD_RSP_OK;
        case (araddr)
            `RXD_A_BUSMODE: rd_val = s_r.busmode;
            `RXD_A_POLL: rd_val = 32'h0000_0000;
            `RXD_A_RXBASE: rd_val = s_r.base;
            `RXD_A_STATUS: begin
                rd_val = s_r.status;
                rd_val[`RXD_PS_HI:`RXD_PS_LO] = ps;
            end
            `RXD_A_OPMODE: rd_val = s_r.opmode;
            `RXD_A_IMASK: rd_val = s_r.imask;
            `RXD_A_MISSED: rd_val = {16'h0000, s_r.missed};
            default: begin
                rd_val = 32'h0000_0000;
                rd_resp = `RXD_RSP_DEC;
            end
        endcase
    end

    // ----------------------------------------
    // Register writes and receive engine
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        poll = 1'b0;
        swr = 1'b0;
        rx_pop = 1'b0;
        rx_drop = 1'b0;
        dw = 32'h0000_0000;
        runt = frm.done && frm.bytes < `RXD_MIN_FRAME;
        big = frm.done || frm.bytes >= `RXD_MIN_FRAME;
        keep = flt_pass(s_r.opmode, frm) && (!runt || s_r.opmode[`RXD_PB]);
        wr_go = s_r.aw_h && s_r.w_h && !s_r.bvalid;
        if (!bus_ok) s_nxt.rstcnt = s_r.rstcnt + 6'h01;
        if (awvalid && awready) begin
            s_nxt.aw_h = 1'b1;
            s_nxt.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_h = 1'b1;
            s_nxt.wdata = wdata;
            s_nxt.wstrb = wstrb;
        end
        if (s_r.bvalid && bready) s_nxt.bvalid = 1'b0;
        if (s_r.rvalid && rready) s_nxt.rvalid = 1'b0;
        if (arvalid && arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_val;
            s_nxt.rresp = rd_resp;
        end
        if (wr_go) begin
            s_nxt.aw_h = 1'b0;
            s_nxt.w_h = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `RXD_RSP_OK;
            case (s_r.awaddr)
                `RXD_A_BUSMODE: begin
                    s_nxt.busmode = merge(s_r.busmode, s_r.wdata, s_r.wstrb);
                    swr = s_nxt.busmode[`RXD_SWR];
                    s_nxt.busmode[`RXD_SWR] = 1'b0;
                end
                `RXD_A_POLL: poll = 1'b1;
                `RXD_A_RXBASE: begin
                    s_nxt.base = merge(s_r.base, s_r.wdata, s_r.wstrb) & ~32'h0000_0003;
                    s_nxt.base_new = 1'b1;
                end
                `RXD_A_STATUS: s_nxt.status = s_r.status & ~merge(32'h0000_0000, s_r.wdata, s_r.wstrb);
                `RXD_A_OPMODE: s_nxt.opmode = merge(s_r.opmode, s_r.wdata, s_r.wstrb);
                `RXD_A_IMASK: s_nxt.imask = merge(s_r.imask, s_r.wdata, s_r.wstrb);
                `RXD_A_MISSED: s_nxt.bresp = `RXD_RSP_OK;
                default: s_nxt.bresp = `RXD_RSP_DEC;
            endcase
        end

        // Engine sets come after the clear so a same-cycle event wins
        unique case (s_r.st)
            S_STOP: begin
                if (run) begin
                    // head only on first start or new base
                    if (!s_r.started || s_r.base_new) s_nxt.cur = s_r.base;
                    s_nxt.started = 1'b1;
                    s_nxt.base_new = 1'b0;
                    s_nxt.mid = 1'b0;
                    s_nxt.widx = 2'h0;
                    s_nxt.st = S_FETCH;
                end
            end
            S_FETCH: begin
                // poll list for an owned descriptor
                if (!s_r.mreq.req) begin
                    s_nxt.mreq = {1'b1, 1'b0, s_r.cur + {28'h0000000, s_r.widx, 2'h0}, 32'h0000_0000};
                end else if (mem_rsp.ack) begin
                    s_nxt.mreq.req = 1'b0;
                    s_nxt.widx = s_r.widx + 2'h1;
                    unique case (s_r.widx)
                        2'h0: begin
                            // flag only after close and next fetch
                            if (s_r.ri_pend) s_nxt.status[`RXD_RI] = 1'b1;
                            s_nxt.ri_pend = 1'b0;
                            // no owned buffer left: suspend in place
                            if (!mem_rsp.rdata[`RXD_OWN]) begin
                                s_nxt.status[`RXD_RBU] = 1'b1;
                                s_nxt.st = S_SUSP;
                            end
                        end
                        2'h1: s_nxt.bsize = mem_rsp.rdata[10:0];
                        2'h2: s_nxt.baddr = mem_rsp.rdata;
                        2'h3: begin
                            s_nxt.nptr = mem_rsp.rdata;
                            s_nxt.off = 11'h000;
                            s_nxt.st = s_r.mid ? S_XFER : S_WAIT;
                        end
                    endcase
                end
            end
            S_WAIT: begin
                if (!run) begin
                    s_nxt.status[`RXD_RPS] = 1'b1;
                    s_nxt.st = S_STOP;
                end else if (frm.head && !keep) begin
                    s_nxt.ret = S_WAIT;
                    s_nxt.st = S_DROP;
                // bus request once 64 bytes or the whole frame are in
                end else if (frm.head && big) begin
                    s_nxt.first = 1'b1;
                    s_nxt.flen = 14'h0000;
                    s_nxt.st = S_XFER;
                end
            end
            S_DROP: begin
                rx_drop = 1'b1;
                s_nxt.st = s_r.ret;
            end
            S_XFER: begin
                if (!s_r.mreq.req) begin
                    if (rx_word.valid) begin
                        rx_pop = 1'b1;
                        s_nxt.mreq = {1'b1, 1'b1, s_r.baddr + {21'h000000, s_r.off}, rx_word.data};
                        s_nxt.lastw = rx_word.last;
                        s_nxt.nb = rx_word.nbytes;
                    end
                end else if (mem_rsp.ack) begin
                    s_nxt.mreq.req = 1'b0;
                    s_nxt.off = s_r.off + `RXD_WORD;
                    s_nxt.flen = s_r.flen + {11'h000, s_r.nb};
                    if (s_r.lastw) begin
                        s_nxt.lseg = 1'b1;
                        s_nxt.st = S_CLOSE;
                    end else if (s_r.off + (`RXD_WORD << 1) > s_r.bsize) begin
                        s_nxt.lseg = 1'b0;
                        s_nxt.st = S_CLOSE;
                    end
                end
            end
            S_CLOSE: begin
                dw[`RXD_FS] = s_r.first;
                dw[`RXD_LS] = s_r.lseg;
                if (s_r.lseg) dw[`RXD_LEN_HI:`RXD_LEN_LO] = s_r.flen;
                if (!s_r.mreq.req) begin
                    s_nxt.mreq = {1'b1, 1'b1, s_r.cur, dw};
                end else if (mem_rsp.ack) begin
                    s_nxt.mreq.req = 1'b0;
                    s_nxt.cur = s_r.nptr;
                    s_nxt.first = 1'b0;
                    s_nxt.mid = !s_r.lseg;
                    s_nxt.ri_pend = s_r.lseg;
                    s_nxt.widx = 2'h0;
                    s_nxt.st = S_FETCH;
                end
            end
            S_SUSP: begin
                if (!run) begin
                    s_nxt.status[`RXD_RPS] = 1'b1;
                    s_nxt.st = S_STOP;
                end else if (poll) begin
                    s_nxt.widx = 2'h0;
                    s_nxt.st = S_FETCH;
                end else if (frm.head && !s_r.mid) begin
                    s_nxt.ret = S_SUSP;
                    s_nxt.st = keep ? S_REFETCH : S_DROP;
                end
            end
            S_REFETCH: begin
                if (!s_r.mreq.req) begin
                    s_nxt.mreq = {1'b1, 1'b0, s_r.cur, 32'h0000_0000};
                end else if (mem_rsp.ack) begin
                    s_nxt.mreq.req = 1'b0;
                    s_nxt.widx = 2'h1;
                    s_nxt.st = S_FETCH;
                    if (!mem_rsp.rdata[`RXD_OWN]) begin
                        s_nxt.missed = s_r.missed + 16'h0001;
                        s_nxt.st = S_DROP;
                    end
                end
            end
            S_FATAL: s_nxt.mreq.req = 1'b0;
        endcase
        if (s_r.mreq.req && mem_rsp.err) begin
            s_nxt.mreq.req = 1'b0;
            s_nxt.status[`RXD_FBE] = 1'b1;
            s_nxt.st = S_FATAL;
        end
        if (swr) begin
            s_nxt = '0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `RXD_RSP_OK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_bus_holdoff:
    assert property (!bus_ok |-> !awready && !wready && !arready) else $error("bus open during reset wait");
    chk_start_fetch:
    assert property (s_r.st == S_STOP && run && !swr |=> s_r.st == S_FETCH) else $error("start did not fetch");
    chk_runt_purge:
    assert property (s_r.st == S_WAIT && run && frm.head && runt && !s_r.opmode[`RXD_PB] && !swr |=> rx_drop)
        else $error("runt frame not purged");
    chk_xfer_min:
    assert property ($rose(s_r.st == S_XFER) && !$past(s_r.mid) |-> $past(frm.bytes) >= `RXD_MIN_FRAME || $past(frm.done))
        else $error("transfer began below minimum");
    chk_close_word:
    assert property (s_r.st == S_CLOSE && s_r.mreq.req |-> !s_r.mreq.wdata[`RXD_OWN] && s_r.mreq.wdata[`RXD_LS] == s_r.lseg)
        else $error("close word wrong");
    chk_single_desc:
    assert property (s_r.st == S_CLOSE && s_r.mreq.req && s_r.lseg && !s_r.mid |-> s_r.mreq.wdata[`RXD_FS])
        else $error("single descriptor lacks first flag");
    chk_ri_order:
    assert property ($rose(s_r.status[`RXD_RI]) |-> $past(s_r.st) == S_FETCH && $past(s_r.ri_pend))
        else $error("receive flag out of order");
    chk_rbu_susp:
    assert property (s_r.st == S_FETCH && s_nxt.st == S_SUSP && !swr |=> s_r.status[`RXD_RBU] ##1 s_r.st != S_XFER)
        else $error("suspend without unavailable flag");
    chk_missed_inc:
    assert property (s_r.st == S_REFETCH && s_nxt.st == S_DROP && !swr |=> rx_drop && s_r.missed == $past(s_r.missed) + 16'h0001)
        else $error("missed frame not counted");
    chk_stop_flag:
    assert property (s_r.st inside {S_WAIT, S_SUSP} && !run && !swr |=> s_r.st == S_STOP && s_r.status[`RXD_RPS])
        else $error("stop not flagged");
    chk_fatal_hold:
    assert property (s_r.st == S_FATAL && !swr |=> s_r.st == S_FATAL && s_r.status[`RXD_FBE] && !s_r.mreq.req)
        else $error("fatal halt released");
endmodule // rxd_dma

// ### logic/rxd_pkg.sv
package rxd_pkg;
    typedef enum logic [3:0] {
        S_STOP = 4'h0, S_FETCH = 4'h1, S_WAIT = 4'h2, S_XFER = 4'h3, S_CLOSE = 4'h4,
        S_SUSP = 4'h5, S_REFETCH = 4'h6, S_DROP = 4'h7, S_FATAL = 4'h8
    } rxd_st_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rxd_mem_req_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } rxd_mem_rsp_t;
    typedef struct packed {
        logic head;
        logic done;
        logic [13:0] bytes;
        logic perf_hit;
        logic hash_hit;
    } rxd_frm_t;
    typedef struct packed {
        logic valid;
        logic last;
        logic [2:0] nbytes;
        logic [31:0] data;
    } rxd_word_t;
    typedef struct packed {
        rxd_st_t st;
        rxd_st_t ret;
        logic [1:0] widx;
        logic [31:0] cur;
        logic [31:0] nptr;
        logic [31:0] baddr;
        logic [10:0] bsize;
        logic [10:0] off;
        logic [13:0] flen;
        logic first;
        logic mid;
        logic lseg;
        logic lastw;
        logic [2:0] nb;
        logic ri_pend;
        logic started;
        logic base_new;
        rxd_mem_req_t mreq;
        logic [31:0] busmode;
        logic [31:0] base;
        logic [31:0] opmode;
        logic [31:0] imask;
        logic [31:0] status;
        logic [15:0] missed;
        logic [5:0] rstcnt;
        logic aw_h;
        logic w_h;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rxd_state_t;
endpackage : rxd_pkg

// ### verif/rxd_mem_model.sv
module rxd_mem_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Host memory port
    input wire rxd_pkg::rxd_mem_req_t mem_req,
    output rxd_pkg::rxd_mem_rsp_t mem_rsp,
    // Test controls: answer delay and forced bus error
    input wire logic [3:0] lat,
    input wire logic fail
);
    timeunit 1ns;
    timeprecision 1ns;
    import rxd_pkg::*;
    logic [31:0] mem [0:255];
    logic [3:0] cnt;
    always @(posedge aclk) begin
        mem_rsp.ack <= 1'b0;
        mem_rsp.err <= 1'b0;
        // Idle read data keeps changing, so a stale word is never trusted
        mem_rsp.rdata <= aresetn ? ~mem_rsp.rdata : 32'h0000_0000;
        if (!aresetn || mem_req.req !== 1'b1 || mem_rsp.ack || mem_rsp.err) begin
            cnt <= 4'h0;
        end else if (cnt != lat) begin
            cnt <= cnt + 4'h1;
        end else if (fail) begin
            mem_rsp.err <= 1'b1;
        end else begin
            mem_rsp.ack <= 1'b1;
            mem_rsp.rdata <= mem[mem_req.addr[9:2]];
            if (mem_req.we) mem[mem_req.addr[9:2]] <= mem_req.wdata;
        end
    end
endmodule // rxd_mem_model

// ### verif/tb_rx_descriptor_dma_process.sv
module tb_rx_descriptor_dma_process;
    timeunit 1ns;
    timeprecision 1ns;
    import rxd_pkg::*;
    localparam logic [7:0] a_bus = 8'h00;
    localparam logic [7:0] a_poll = 8'h04;
    localparam logic [7:0] a_base = 8'h08;
    localparam logic [7:0] a_st = 8'h0C;
    localparam logic [7:0] a_op = 8'h10;
    localparam logic [7:0] a_im = 8'h14;
    localparam logic [7:0] a_mis = 8'h18;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic fail = 1'b0;
    logic hit = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] lat = 4'h1;
    logic [5:0] flen = 6'h10;
    logic [5:0] fptr = 6'h00;
    logic [7:0] pushed = 8'h00;
    logic [7:0] used = 8'h00;
    logic [7:0] ndrop = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, rx_pop, rx_drop;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, v;
    rxd_mem_req_t mem_req;
    rxd_mem_rsp_t mem_rsp;
    rxd_frm_t frm;
    rxd_word_t rx_word;
    int fails = 0;
    int checks = 0;

    always #50 aclk = ~aclk;

    rxd_dma rxd_dma_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .mem_req(mem_req), .mem_rsp(mem_rsp),
        .frm(frm), .rx_word(rx_word), .rx_pop(rx_pop), .rx_drop(rx_drop));
    rxd_mem_model rxd_mem_model_inst (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .mem_rsp(mem_rsp),
        .lat(lat), .fail(fail));

    // ----------------------------------------
    // Receive FIFO stand-in: equal frames of flen words
    // ----------------------------------------
    assign frm = '{pushed != used, 1'b1, {6'h00, flen, 2'h0}, hit, 1'b0};
    assign rx_word = '{pushed != used, fptr == flen - 6'h01, 3'h4, {16'hA5C3, 10'h000, fptr}};
    always @(posedge aclk) begin
        if (rx_drop === 1'b1) begin
            ndrop <= ndrop + 8'h01;
            used <= used + 8'h01;
            fptr <= 6'h00;
        end else if (rx_pop === 1'b1) begin
            fptr <= rx_word.last ? 6'h00 : fptr + 6'h01;
            used <= used + {7'h00, rx_word.last};
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) resp = bresp;
            if (bvalid === 1'b1) bready <= 1'b0;
        end while (bready);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) v = rdata;
            if (rvalid === 1'b1) resp = rresp;
            if (rvalid === 1'b1) rready <= 1'b0;
        end while (rready);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(v & m, e);
    endtask

    // Polls a register until the masked value appears, bounded
    task automatic wt(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            rd(a);
            n++;
        end while ((v & m) !== e && n < 16'h0190);
        chk(v & m, e);
    endtask

    task automatic wdrop(input logic [7:0] n);
        int k;
        k = 0;
        while (ndrop != n && k < 16'h0400) begin
            @(posedge aclk);
            k++;
        end
        chk({24'h0, ndrop}, {24'h0, n});
    endtask

    task automatic push(input logic [5:0] w, input logic h, input logic [7:0] n);
        flen <= w;
        hit <= h;
        pushed <= pushed + n;
    endtask

    function automatic logic [31:0] mw(input logic [7:0] i);
        return rxd_mem_model_inst.mem[i];
    endfunction

    task automatic desc(input logic [7:0] i, input logic own, input logic [31:0] sz, input logic [31:0] nx);
        rxd_mem_model_inst.mem[i] = {own, 31'h0};
        rxd_mem_model_inst.mem[i + 8'h01] = sz;
        rxd_mem_model_inst.mem[i + 8'h02] = {22'h0, i, 2'h0} + 32'h0000_0100;
        rxd_mem_model_inst.mem[i + 8'h03] = nx;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_boot;
        int n;
        n = 0;
        aresetn <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (awready !== 1'b1 && n < 16'h0040);
        chk({31'h0, n > 16'h0031 && n < 16'h0036}, 32'h1);
        $display("test boot ended");
    endtask

    task automatic t_regs;
        rc(a_op, 32'hFFFF_FFFF, 32'h0);
        rc(a_st, 32'hFFFF_FFFF, 32'h0);
        wr(a_mis, 32'h0000_FFFF);
        chk({30'h0, resp}, 32'h0);
        rc(a_mis, 32'hFFFF_FFFF, 32'h0);
        rd(8'h3C);
        chk(v, 32'h0);
        chk({30'h0, resp}, 32'h3);
        $display("test registers ended");
    endtask

    task automatic t_purge;
        logic [31:0] md [4];
        logic [3:0] hm;
        md = '{32'h2, 32'h6, 32'h3, 32'h42};
        hm = 4'hA;
        desc(8'h40, 1'b1, 32'h100, 32'h110);
        desc(8'h44, 1'b0, 32'h20, 32'h120);
        desc(8'h48, 1'b1, 32'h100, 32'h130);
        desc(8'h4C, 1'b0, 32'h100, 32'h100);
        wr(a_bus, 32'h0);
        wr(a_im, 32'h0001_A5C3);
        rc(a_im, 32'hFFFF_FFFF, 32'h0001_A5C3);
        wr(a_base, 32'h0000_0103);
        rc(a_base, 32'hFFFF_FFFF, 32'h100);
        wr(a_op, 32'h2);
        wt(a_st, 32'h000E_0000, 32'h0006_0000);
        push(6'h08, 1'b1, 8'h01);
        wdrop(8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(a_op, md[i]);
            push(6'h10, hm[i], 8'h01);
            wdrop(8'h02 + i[7:0]);
        end
        wr(a_op, 32'h2);
        chk(mw(8'h40), 32'h8000_0000);
        $display("test purge ended");
    endtask

    task automatic t_single;
        lat <= 4'h3;
        push(6'h10, 1'b1, 8'h01);
        wt(a_st, 32'h000E_0080, 32'h0008_0080);
        chk(mw(8'h40), 32'h0040_0300);
        chk(mw(8'h80), 32'hA5C3_0000);
        chk(mw(8'h8F), 32'hA5C3_000F);
        rc(a_st, 32'h40, 32'h40);
        wr(a_st, 32'h40);
        rc(a_st, 32'hC0, 32'h80);
        push(6'h10, 1'b1, 8'h02);
        wdrop(8'h07);
        rc(a_mis, 32'hFFFF, 32'h2);
        chk(mw(8'h44), 32'h0);
        $display("test single ended");
    endtask

    task automatic t_chain;
        rxd_mem_model_inst.mem[8'h44] = 32'h8000_0000;
        wr(a_poll, 32'h1);
        wt(a_st, 32'h000E_0000, 32'h0006_0000);
        lat <= 4'h0;
        push(6'h10, 1'b1, 8'h01);
        wt(a_st, 32'h000E_0000, 32'h0008_0000);
        chk(mw(8'h44) & 32'h8000_0300, 32'h200);
        chk(mw(8'h48), 32'h0040_0100);
        chk(mw(8'h84), 32'hA5C3_0000);
        wr(a_op, 32'h0);
        wt(a_st, 32'h000E_0100, 32'h0000_0100);
        $display("test chain ended");
    endtask

    task automatic t_fatal;
        int k;
        k = 0;
        fail <= 1'b1;
        wr(a_op, 32'h2);
        while (mem_req.req !== 1'b1 && k < 16'h0100) begin
            @(posedge aclk);
            k++;
        end
        chk(mem_req.addr, 32'h130);
        wt(a_st, 32'h000E_2000, 32'h0002_2000);
        fail <= 1'b0;
        repeat (8'h20) @(posedge aclk);
        chk({31'h0, mem_req.req}, 32'h0);
        wr(a_bus, 32'h1);
        repeat (8'h34) @(posedge aclk);
        rc(a_st, 32'hFFFF_FFFF, 32'h0);
        rc(a_mis, 32'hFFFF, 32'h0);
        wr(a_base, 32'h100);
        wr(a_op, 32'h2);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8'h34) @(posedge aclk);
        rc(a_op, 32'hFFFF_FFFF, 32'h0);
        rc(a_st, 32'h000E_0000, 32'h0);
        $display("test fatal and reset ended");
    endtask

    initial begin
        repeat (4'h3) @(posedge aclk);
        t_boot;
        t_regs;
        t_purge;
        t_single;
        t_chain;
        t_fatal;
        stop_test;
    end

    // Whole run needs well under this many cycles
    initial begin
        repeat (32'h0000_9C40) @(posedge aclk);
        fails++;
        stop_test;
    end
endmodule // tb_rx_descriptor_dma_process
